// File: verification/sbm_host_model.sv
// Purpose: expansion-bus host model for the shared memory
// Assumes: one byte per access, taken at one edge
// Notes: idle lines show inverted leftovers, never a frozen copy
`timescale 1ns/100ps
`default_nettype none
module sbm_host_model (
  input wire logic clk_i, // Clock
  input wire logic [7:0] host_rdata_i, // Read data
  input wire logic host_ack_i, // Access done
  output var sbm_pkg::sbm_port_req_type host_req_o // Byte access
);
  import sbm_pkg::*;
  logic [7:0] rd_last;
  logic ack_last;
  initial host_req_o = '0;
  // Ring loads, commands and status clears all go through here
  task automatic access(input logic wr, input logic [10:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1 host_req_o = '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(posedge clk_i);
    // Answer is settled one step after the taking edge
    #1 rd_last = host_rdata_i;
    ack_last = host_ack_i;
    host_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule
`default_nettype wire

// File: verification/sbm_shared_buffer_memory_monitor.sv
// Purpose: port checker for the shared buffer memory
// Assumes: one clock, async low reset
// Notes: bound to the top module below
`timescale 1ns/100ps
`default_nettype none
module sbm_shared_buffer_memory_monitor (
  input wire logic clk_i, // Clock
  input wire logic arst_n_i, // Reset
  input wire logic ce_i, // Enable
  input wire sbm_pkg::sbm_port_req_type host_req_i, // Host access
  input wire logic [7:0] host_rdata_o, // Host data
  input wire logic host_ack_o, // Host done
  input wire sbm_pkg::sbm_port_req_type ctl_req_i, // Ctl access
  input wire logic [7:0] event_i, // Events
  input wire logic sign_done_o, // Fill done
  input wire logic host_irq_o, // Irq
  input wire logic cmd_valid_o, // Cmd valid
  input wire sbm_pkg::sbm_cmd_word_type cmd_o, // Cmd word
  input wire logic cmd_ready_i // Cmd taken
);
  import sbm_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  // ====
  // Decodes
  wire logic h_go = ce_i && (host_req_i.rd || host_req_i.wr);
  wire logic h_irq_rd = ce_i && host_req_i.rd && host_req_i.addr inside {[11'h3FC:11'h3FF]};
  wire logic c_irq_wr = ce_i && ctl_req_i.wr && ctl_req_i.addr inside {[11'h3FC:11'h3FF]};
  wire logic h_cmd_wr = ce_i && host_req_i.wr && host_req_i.addr inside {[11'h3FC:11'h3FF], [11'h7FE:11'h7FF]};
  sequence s_event;
    ce_i && event_i != 8'h00;
  endsequence
  sequence s_status_rd;
    ce_i && host_req_i.rd && !host_req_i.wr && host_req_i.addr == SBM_INT_STATUS_PRIMARY;
  endsequence
  // ====
  // Properties
  a_ack_after_req: assert property (h_go |=> host_ack_o) else $error("host ack missing");
  a_no_stray_ack: assert property (ce_i && !h_go |=> !host_ack_o) else $error("stray host ack");
  a_sign_done_holds: assert property (sign_done_o |=> sign_done_o) else $error("fill flag dropped");
  a_status_or_in: assert property (s_event ##1 s_status_rd |=> (host_rdata_o & $past(event_i, 2)) == $past(event_i, 2))
    else $error("status bit lost");
  a_irq_set: assert property (c_irq_wr && sign_done_o && !h_irq_rd |=> host_irq_o) else $error("irq not set");
  a_irq_clear: assert property (h_irq_rd && !(ce_i && ctl_req_i.wr) |=> !host_irq_o) else $error("irq kept");
  a_cmd_latency: assert property (h_cmd_wr ##1 ce_i |-> ##1 cmd_valid_o) else $error("command late");
  a_cmd_stands: assert property (cmd_valid_o && !cmd_ready_i && ce_i |=> cmd_valid_o && $stable(cmd_o))
    else $error("command not held");
endmodule
bind sbm_shared_buffer_memory sbm_shared_buffer_memory_monitor u_monitor (.clk_i, .arst_n_i, .ce_i, .host_req_i,
  .host_rdata_o, .host_ack_o, .ctl_req_i, .event_i, .sign_done_o, .host_irq_o, .cmd_valid_o, .cmd_o, .cmd_ready_i);
`default_nettype wire

// File: verification/sbm_shared_buffer_memory_test.sv
// Purpose: self-checking bench for the shared buffer memory
// Assumes: 10 MHz clock, inputs driven 1 ns after the edge
// Notes: plain cases in a table, awkward ones by hand
`timescale 1ns/100ps
`default_nettype none
module sbm_shared_buffer_memory_test;
  import sbm_pkg::*;
  typedef struct packed {logic [10:0] addr; logic [7:0] data;} sbm_row_type;
  localparam logic [87:0] SIG = 88'h5348415245444255463132; // Arbitrary text
  sbm_row_type rows [6] = '{'{11'h08E, 8'hA5}, '{11'h094, 8'h5A}, '{11'h114, 8'h3C}, '{11'h120, 8'hC3},
    '{11'h3C1, 8'h96}, '{11'h7F1, 8'h69}};
  logic clk_i = 1'b0, arst_n_i = 1'b0, ce_i = 1'b1, ctl_or_i = 1'b0, cmd_ready_i = 1'b1, saw_ovf = 1'b0;
  sbm_port_req_type host_req_i, ctl_req_i = '0;
  logic [7:0] host_rdata_o, ctl_rdata_o, event_i = 8'h00;
  logic [3:0] event_axes_i = 4'h0;
  logic host_ack_o, ctl_ack_o, sign_done_o, host_irq_o, cmd_valid_o, cmd_overflow_o;
  sbm_cmd_word_type cmd_o;
  int errors = 0, cmp_count = 0, cycles = 0;
  sbm_shared_buffer_memory DUT (.clk_i, .arst_n_i, .ce_i, .host_req_i, .host_rdata_o, .host_ack_o, .ctl_req_i,
    .ctl_or_i, .ctl_rdata_o, .ctl_ack_o, .event_i, .event_axes_i, .signature_i(SIG), .sign_done_o, .host_irq_o,
    .cmd_valid_o, .cmd_o, .cmd_ready_i, .cmd_overflow_o);
  sbm_host_model HOST (.clk_i, .host_rdata_i(host_rdata_o), .host_ack_i(host_ack_o), .host_req_o(host_req_i));
  initial forever #50 clk_i = ~clk_i;
  // ====
  // Shared tasks
  task automatic check(input logic [87:0] got, input logic [87:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic hr(input logic [10:0] a, input logic [7:0] e);
    HOST.access(1'b0, a, 8'h00);
    check({HOST.ack_last, HOST.rd_last}, {1'b1, e});
  endtask
  task automatic ctl(input logic wr, input logic [10:0] a, input logic [7:0] d, input logic o, output logic [8:0] r);
    @(posedge clk_i);
    #1 ctl_req_i = '{wr: wr, rd: !wr, addr: a, wdata: d};
    ctl_or_i = o;
    @(posedge clk_i);
    #1 r = {ctl_ack_o, ctl_rdata_o};
    ctl_req_i = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    ctl_or_i = 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Whole run is well under a thousand cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cmd_overflow_o === 1'b1) saw_ovf = 1'b1;
    if (cycles == 5000) begin
      errors++;
      tally_and_finish();
    end
  end
  // ====
  // Main sequence
  initial begin
    logic [8:0] r;
    logic [7:0] acc;
    int n;
    repeat (3) @(posedge clk_i);
    #1 arst_n_i = 1'b1;
    check({sign_done_o, host_irq_o, cmd_valid_o}, 3'b000);
    ctl(1'b1, 11'h300, 8'h3C, 1'b0, r);
    check(r[8], 1'b0);
    for (n = 0; n < 40 && sign_done_o !== 1'b1; n++) @(posedge clk_i);
    for (n = 0; n < SBM_SIG_LEN; n++) hr(11'(SBM_SIGWIN_LO + n), SIG[87 - 8 * n -: 8]);
    hr(SBM_INT_STATUS_PRIMARY, SBM_STATUS_RESET);
    $display("Test reset_signature done");
    foreach (rows[i]) begin
      HOST.access(1'b1, rows[i].addr, rows[i].data);
      hr(rows[i].addr, rows[i].data);
      ctl(1'b0, rows[i].addr, 8'h00, 1'b0, r);
      check(r, {1'b1, rows[i].data});
    end
    ctl(1'b1, 11'h08E, 8'h0F, 1'b1, r);
    hr(11'h08E, 8'hAF);
    $display("Test table done");
    HOST.access(1'b1, SBM_INT_STATUS_PRIMARY, 8'h00);
    acc = 8'h00;
    for (n = 0; n < 8; n++) begin
      HOST.access(1'b1, 11'(SBM_AXIS_SRC_BASE + n), 8'h00);
      event_i = 8'(1 << n);
      event_axes_i = 4'(n + 1);
      @(posedge clk_i);
      #1 event_i = 8'h00;
      acc[n] = 1'b1;
      repeat (6) @(posedge clk_i);
      hr(SBM_INT_STATUS_PRIMARY, acc);
      hr(11'(SBM_AXIS_SRC_BASE + n), 8'(n + 1));
    end
    HOST.access(1'b1, SBM_INT_STATUS_PRIMARY, 8'h00);
    hr(SBM_INT_STATUS_PRIMARY, 8'h00);
    // Event one cycle before a status read: new bit must already show
    event_i = 8'h40;
    fork
      hr(SBM_INT_STATUS_PRIMARY, 8'h40);
      begin
        @(posedge clk_i);
        #1 event_i = 8'h00;
      end
    join
    // Event on the very edge of a host clear: the set wins
    fork
      HOST.access(1'b1, SBM_INT_STATUS_PRIMARY, 8'h00);
      begin
        @(posedge clk_i);
        #1 event_i = 8'h80;
        @(posedge clk_i);
        #1 event_i = 8'h00;
      end
    join
    hr(SBM_INT_STATUS_PRIMARY, 8'h80);
    $display("Test status done");
    ctl(1'b1, SBM_CMD_A_LO, 8'h11, 1'b0, r);
    #1 check(host_irq_o, 1'b1);
    hr(SBM_CMD_A_LO, 8'h11);
    #1 check(host_irq_o, 1'b0);
    cmd_ready_i = 1'b0;
    for (n = 0; n < 6; n++) HOST.access(1'b1, n < 4 ? 11'(11'h3FC + n) : 11'(11'h7FA + n), 8'(8'hC0 + n));
    // One word sits in the output stage, four in the queue, the sixth is dropped
    cmd_ready_i = 1'b1;
    n = 0;
    repeat (12) begin
      if (cmd_valid_o === 1'b1) begin
        check(cmd_o, {8'(8'hC0 + n), n < 4 ? 11'(11'h3FC + n) : 11'(11'h7FA + n)});
        n++;
      end
      @(posedge clk_i);
      #1;
    end
    check(n, 5);
    check(saw_ovf, 1'b1);
    $display("Test command_irq done");
    fork
      HOST.access(1'b1, 11'h200, 8'h77);
      ctl(1'b1, 11'h200, 8'h88, 1'b0, r);
    join
    hr(11'h200, 8'h77);
    $display("Test collision done");
    @(posedge clk_i);
    #1 ce_i = 1'b0;
    HOST.access(1'b1, 11'h200, 8'h55);
    check(HOST.ack_last, 1'b0);
    ce_i = 1'b1;
    hr(11'h200, 8'h77);
    $display("Test clock_enable done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// File: verilog/sbm_fifo.sv
// Purpose: small valid/ready FIFO for host command-window writes
// Assumes: single clock, clock enable freezes all state
// Notes: full and empty come from an occupancy count
`timescale 1ns/100ps
`default_nettype none
module sbm_fifo #(
  parameter int unsigned WIDTH = 19,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clk_i, // Clock
  input wire logic arst_n_i, // Async reset, low
  input wire logic ce_i, // Clock enable
  input wire logic [WIDTH-1:0] in_data_i, // Write data
  input wire logic in_valid_i, // Write request
  output logic in_ready_o, // Space available
  output logic [WIDTH-1:0] out_data_o, // Head word
  output logic out_valid_o, // Head valid
  input wire logic out_ready_i // Consumer takes head
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wptr;
  logic [PW-1:0] rptr;
  logic [PW:0] count;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;

  // Count is one bit wider than the pointers so that full can be told from empty
  assign in_ready_o = (count != (PW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rptr];

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else if (ce_i) begin
      if (push) wptr <= wptr + 1'b1;
      if (pop) rptr <= rptr + 1'b1;
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // Storage carries no reset; data is qualified by count
  always_ff @(posedge clk_i) begin
    if (ce_i && push) mem[wptr] <= in_data_i;
  end
endmodule
`default_nettype wire

// File: verilog/sbm_pkg.sv
// Purpose: constants and types for the shared host/controller buffer memory
// Assumes: byte-wide memory, 11-bit byte address, one clock
// Notes: address map of the functional blocks and status bit positions
package sbm_pkg;

  // ==========================================================
  // Geometry
  localparam int unsigned SBM_BYTES = 2048;
  localparam int unsigned SBM_AW = 11;
  localparam int unsigned SBM_FIFO_DEPTH = 4;
  localparam int unsigned SBM_FIFO_W = 8 + SBM_AW;

  // ==========================================================
  // Block boundaries
  localparam logic [10:0] SBM_STATUS_LO = 11'h000;
  localparam logic [10:0] SBM_STATUS_HI = 11'h08D;
  localparam logic [10:0] SBM_HWSIG_LO = 11'h08E;
  localparam logic [10:0] SBM_HWSIG_HI = 11'h093;
  localparam logic [10:0] SBM_PARAM_LO = 11'h094;
  localparam logic [10:0] SBM_PARAM_HI = 11'h114;
  localparam logic [10:0] SBM_SIGWIN_LO = 11'h115;
  localparam logic [10:0] SBM_SIGWIN_HI = 11'h11F;
  localparam logic [10:0] SBM_RING2_LO = 11'h120;
  localparam logic [10:0] SBM_RING2_HI = 11'h3C1;
  localparam logic [10:0] SBM_RINGS_LO = 11'h400;
  localparam logic [10:0] SBM_RINGS_HI = 11'h7F1;
  localparam logic [10:0] SBM_CMD_A_LO = 11'h3FC;
  localparam logic [10:0] SBM_CMD_A_HI = 11'h3FF;
  localparam logic [10:0] SBM_CMD_B_LO = 11'h7FE;
  localparam logic [10:0] SBM_CMD_B_HI = 11'h7FF;
  localparam logic [10:0] SBM_IRQ_LO = 11'h3FC;
  localparam logic [10:0] SBM_IRQ_HI = 11'h7FF;

  // ==========================================================
  // Status byte and axis source bytes
  localparam logic [10:0] SBM_INT_STATUS_PRIMARY = 11'h000;
  localparam logic [10:0] SBM_AXIS_SRC_BASE = 11'h001;
  localparam logic [7:0] SBM_STATUS_RESET = 8'h00;
  localparam int unsigned SBM_BIT_FE_HALT = 0;
  localparam int unsigned SBM_BIT_FE = 1;
  localparam int unsigned SBM_BIT_INDEX = 2;
  localparam int unsigned SBM_BIT_BREAKPT = 3;
  localparam int unsigned SBM_BIT_MOTION_DONE = 4;
  localparam int unsigned SBM_BIT_PROBE = 5;
  localparam int unsigned SBM_BIT_CONFLICT = 6;
  localparam int unsigned SBM_BIT_CMD_IGNORED = 7;
  localparam logic [7:0] SBM_AXIS_MASK = 8'h0F;

  // Power-up signature length in bytes (115h..11Fh)
  localparam int unsigned SBM_SIG_LEN = 11;
  localparam logic [3:0] SBM_SIG_LAST = 4'hA;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [10:0] addr;
    logic [7:0] wdata;
  } sbm_port_req_type;

  typedef struct packed {
    logic [7:0] data;
    logic [10:0] addr;
  } sbm_cmd_word_type;

  typedef enum logic [1:0] {
    SBM_ST_SIGN = 2'b00,
    SBM_ST_RUN = 2'b01
  } sbm_state_type;

  // Which functional block an address falls in
  typedef enum logic [2:0] {
    SBM_BLK_STATUS = 3'b000,
    SBM_BLK_HWSIG = 3'b001,
    SBM_BLK_PARAM = 3'b010,
    SBM_BLK_SIGWIN = 3'b011,
    SBM_BLK_RING2 = 3'b100,
    SBM_BLK_RINGS = 3'b101,
    SBM_BLK_CMD = 3'b110,
    SBM_BLK_GAP = 3'b111
  } sbm_block_type;

endpackage

// File: verilog/sbm_shared_buffer_memory.sv
// Purpose: 2048-byte shared memory between expansion-bus host and controller
// Assumes: both ports synchronous to clk_i; one byte per access
// Notes: access codes and access bytes are software conventions only
`timescale 1ns/100ps
`default_nettype none
module sbm_shared_buffer_memory (
  input wire logic clk_i, // 10 MHz clock
  input wire logic arst_n_i, // Async reset, low
  input wire logic ce_i, // Clock enable
  input wire sbm_pkg::sbm_port_req_type host_req_i, // Host byte access
  output logic [7:0] host_rdata_o, // Host read data
  output logic host_ack_o, // Host access done
  input wire sbm_pkg::sbm_port_req_type ctl_req_i, // Controller byte access
  input wire logic ctl_or_i, // Controller write is OR
  output logic [7:0] ctl_rdata_o, // Controller read data
  output logic ctl_ack_o, // Controller access done
  input wire logic [7:0] event_i, // Status event pulses
  input wire logic [3:0] event_axes_i, // Axes causing events
  input wire logic [87:0] signature_i, // Power-up signature text
  output logic sign_done_o, // Signature written
  output logic host_irq_o, // Interrupt to host
  output logic cmd_valid_o, // Command byte present
  output sbm_pkg::sbm_cmd_word_type cmd_o, // Command byte and address
  input wire logic cmd_ready_i, // Controller takes command
  output logic cmd_overflow_o // Command dropped, FIFO full
);
  import sbm_pkg::*;

  // ==========================================================
  // Address decode
  function automatic sbm_block_type blk_of(input logic [10:0] a);
    if (a <= SBM_STATUS_HI) return SBM_BLK_STATUS;
    else if (a <= SBM_HWSIG_HI) return SBM_BLK_HWSIG;
    else if (a <= SBM_PARAM_HI) return SBM_BLK_PARAM;
    else if (a <= SBM_SIGWIN_HI) return SBM_BLK_SIGWIN;
    else if (a <= SBM_RING2_HI) return SBM_BLK_RING2;
    else if ((a >= SBM_CMD_A_LO && a <= SBM_CMD_A_HI) || a >= SBM_CMD_B_LO) return SBM_BLK_CMD;
    else if (a >= SBM_RINGS_LO && a <= SBM_RINGS_HI) return SBM_BLK_RINGS;
    else return SBM_BLK_GAP;
  endfunction

  function automatic logic is_axis_src(input logic [10:0] a);
    return (a >= SBM_AXIS_SRC_BASE) && (a <= SBM_AXIS_SRC_BASE + 11'h007);
  endfunction

  // ==========================================================
  // Storage
  // One 2048-entry array for every byte but the status byte, which is held in flops; no port has hardware protection
  logic [7:0] mem [SBM_BYTES];
  sbm_state_type state;
  sbm_state_type next_state;
  logic [3:0] sig_idx;
  logic [7:0] status_or;
  logic [3:0] axes_held;
  logic [7:0] ev_pending;
  // Status byte lives in flops so that it has a reset value
  logic [7:0] int_status;

  // ==========================================================
  // Port arbitration and write resolution
  wire sbm_block_type host_blk = blk_of(host_req_i.addr);
  wire host_cmd_wr = host_req_i.wr && (host_blk == SBM_BLK_CMD);
  wire fifo_in_ready;
  wire sign_wr = (state == SBM_ST_SIGN);
  wire [10:0] sign_addr = SBM_SIGWIN_LO + {7'h00, sig_idx};
  wire [7:0] sign_byte = signature_i[8*(SBM_SIG_LEN-1-int'(sig_idx)) +: 8];
  // Controller is blocked during signature fill
  wire ctl_wr = ctl_req_i.wr && !sign_wr;
  wire [7:0] ctl_cur = (ctl_req_i.addr == SBM_INT_STATUS_PRIMARY) ? int_status : mem[ctl_req_i.addr];
  wire [7:0] host_cur = (host_req_i.addr == SBM_INT_STATUS_PRIMARY) ? int_status : mem[host_req_i.addr];
  wire [7:0] ctl_wval = ctl_or_i ? (ctl_cur | ctl_req_i.wdata) : ctl_req_i.wdata;
  // Same byte both sides: host value is stored unless it is a command-window write with the FIFO full; controller write is lost
  wire collide = host_req_i.wr && ctl_wr && (host_req_i.addr == ctl_req_i.addr);
  // Hardware events OR into status byte and source bytes
  wire ev_any = |ev_pending;
  wire ev_slot = ev_any && !ctl_wr && !sign_wr;
  logic [2:0] ev_bit;
  always_comb begin
    ev_bit = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (ev_pending[i]) ev_bit = 3'(i);
    end
  end
  wire [10:0] ev_src_addr = SBM_AXIS_SRC_BASE + {8'h00, ev_bit};
  wire ev_src_host_hit = host_req_i.wr && (host_req_i.addr == ev_src_addr);
  wire st_host_wr = host_req_i.wr && (host_req_i.addr == SBM_INT_STATUS_PRIMARY);
  // Status byte held in flops so hardware set beats host clear
  assign status_or = event_i;
  wire [7:0] status_cur = int_status;
  wire [7:0] status_next = (st_host_wr ? host_req_i.wdata : status_cur) | status_or;
  // Controller write to the status byte can only add bits; host wins a collision
  wire ctl_st_wr = ctl_wr && (ctl_req_i.addr == SBM_INT_STATUS_PRIMARY);
  wire [7:0] next_int_status = status_next | ((ctl_st_wr && !st_host_wr) ? ctl_wval : 8'h00);

  always_comb begin
    next_state = state;
    unique case (state)
      SBM_ST_SIGN: if (sig_idx == SBM_SIG_LAST) next_state = SBM_ST_RUN;
      SBM_ST_RUN: next_state = SBM_ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= SBM_ST_SIGN;
      sig_idx <= 4'h0;
      axes_held <= 4'h0;
      ev_pending <= 8'h00;
      int_status <= SBM_STATUS_RESET;
    end else if (ce_i) begin
      state <= next_state;
      if (sign_wr) sig_idx <= sig_idx + 4'h1;
      if (|event_i) axes_held <= event_axes_i;
      ev_pending <= (ev_slot ? (ev_pending & ~(8'h01 << ev_bit)) : ev_pending) | event_i;
      int_status <= next_int_status;
    end
  end

  // Memory write ports; status byte always ORs in new events
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (sign_wr) mem[sign_addr] <= sign_byte;
      if (ctl_wr && !collide && ctl_req_i.addr != SBM_INT_STATUS_PRIMARY) mem[ctl_req_i.addr] <= ctl_wval;
      if (host_req_i.wr && !host_cmd_wr && host_req_i.addr != SBM_INT_STATUS_PRIMARY) begin
        mem[host_req_i.addr] <= host_req_i.wdata;
      end
      if (host_cmd_wr && fifo_in_ready) mem[host_req_i.addr] <= host_req_i.wdata;
      // Axis bits still land when the host writes the same source byte
      if (ev_slot) begin
        mem[ev_src_addr] <= (ev_src_host_hit ? host_req_i.wdata : mem[ev_src_addr]) | {4'h0, axes_held};
      end
    end
  end

  // ==========================================================
  // Command window queue
  sbm_cmd_word_type fifo_out;
  wire fifo_out_valid;
  wire fifo_take = fifo_out_valid && (!cmd_valid_o || cmd_ready_i);
  sbm_fifo #(
    .WIDTH(SBM_FIFO_W),
    .DEPTH(SBM_FIFO_DEPTH)
  ) u_cmd_fifo (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .in_data_i({host_req_i.wdata, host_req_i.addr}),
    .in_valid_i(host_cmd_wr),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_out),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_take)
  );

  // ==========================================================
  // Registered outputs
  wire irq_region_wr = ctl_wr && (ctl_req_i.addr >= SBM_IRQ_LO) && (blk_of(ctl_req_i.addr) != SBM_BLK_RINGS);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      host_rdata_o <= 8'h00;
      host_ack_o <= 1'b0;
      ctl_rdata_o <= 8'h00;
      ctl_ack_o <= 1'b0;
      sign_done_o <= 1'b0;
      host_irq_o <= 1'b0;
      cmd_valid_o <= 1'b0;
      cmd_o <= '0;
      cmd_overflow_o <= 1'b0;
    end else if (ce_i) begin
      host_rdata_o <= host_cur;
      host_ack_o <= host_req_i.rd || host_req_i.wr;
      ctl_rdata_o <= ctl_cur;
      ctl_ack_o <= (ctl_req_i.rd || ctl_req_i.wr) && !sign_wr;
      sign_done_o <= (state == SBM_ST_RUN);
      // Controller write in the interrupt region raises, host read there lowers
      if (irq_region_wr) begin
        host_irq_o <= 1'b1;
      end else if (host_req_i.rd && host_req_i.addr >= SBM_IRQ_LO && blk_of(host_req_i.addr) != SBM_BLK_RINGS) begin
        host_irq_o <= 1'b0;
      end
      if (fifo_take) begin
        cmd_valid_o <= 1'b1;
        cmd_o <= fifo_out;
      end else if (cmd_ready_i) begin
        cmd_valid_o <= 1'b0;
      end
      cmd_overflow_o <= host_cmd_wr && !fifo_in_ready;
    end
  end
endmodule
`default_nettype wire
